// file: adc_conversion_reference_control.sv
// Converter control: conversion sequencer, serial port and reference mode
// Operation
// - A convert-start rising edge while idle begins sampling and conversion.
// - Serial port opens only on convert-start fall with shift clock high.
// - Serial output takes the result MSB at select, then changes only on shift clock falling edges.
// - Serial input is captured on shift clock rising edges.
// - Shift clock activity while deselected never advances the output.
// - Reference operation is chosen from the serially written configuration word.
// - Mode field is bits five and four, four modes zero to three.
// - Mode 00: bandgap drives its pin, buffer active.
// - Mode 01: bandgap disconnected, buffer drives from external source.
// - Mode 10: bandgap drives its pin, buffer shut down.
// - Mode 11: bandgap and buffer both shut down.
// - Internally clocked 18-bit resolution, then 500 ns acquisition.
// - Result read belongs to the same conversion, no pipeline delay.
// - Result available within 1.5 us of the convert-start rise.
module adc_conversion_reference_control
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic convertStartPin,
  input wire logic shiftClkPin,
  input wire logic serialInPin,
  input wire logic compKeep,
  output logic [RESULT_BITS-1:0] dacCode,
  output logic trackHold,
  output logic resultReady,
  output logic serialOut,
  output logic serialOutEn,
  output logic [1:0] refMode,
  output logic bandgapOutputSwitch,
  output logic bufferPathSwitch
);
  // ***************************************
  // Input synchronisation
  // ***************************************
  logic [SYNC_BITS-1:0] syncIn;
  logic cnvRise;
  logic cnvFall;
  logic shiftRise;
  logic shiftFall;
  logic shiftLevel;
  logic serialIn;

  signal_sync #(.WIDTH(SYNC_BITS)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .asyncIn({convertStartPin, shiftClkPin, serialInPin}),
    .syncOut(syncIn)
  );

  edge_detect u_cnv_edge (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .level(syncIn[SYNC_CNV]),
    .rise(cnvRise),
    .fall(cnvFall)
  );

  edge_detect u_sclk_edge (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .level(syncIn[SYNC_SCLK]),
    .rise(shiftRise),
    .fall(shiftFall)
  );

  assign shiftLevel = syncIn[SYNC_SCLK];
  assign serialIn = syncIn[SYNC_DIN];

  // ***************************************
  // Conversion sequencer
  // ***************************************
  conv_state_t state;
  conv_state_t next_state;
  logic [5:0] count;
  logic [5:0] next_count;
  logic [4:0] bitPtr;
  logic [4:0] next_bitPtr;
  logic [RESULT_BITS-1:0] next_dacCode;
  logic [RESULT_BITS-1:0] result;
  logic [RESULT_BITS-1:0] next_result;
  logic next_trackHold;
  logic next_resultReady;

  always_comb begin
    next_state = state;
    next_count = count;
    next_bitPtr = bitPtr;
    next_dacCode = dacCode;
    next_result = result;
    next_trackHold = trackHold;
    next_resultReady = 1'b0;
    case (state)
      ST_IDLE: begin
        // Edges during convert or acquire are ignored
        if (cnvRise) begin
          next_state = ST_CONVERT;
          next_trackHold = 1'b0;
          next_bitPtr = MSB_INDEX;
          next_dacCode = RESULT_RESET;
          next_dacCode[MSB_INDEX] = 1'b1;
        end
      end
      ST_CONVERT: begin
        // One trial bit per internal clock cycle
        if (!compKeep) begin
          next_dacCode[bitPtr] = 1'b0;
        end
        if (bitPtr != 5'h00) begin
          next_bitPtr = bitPtr - 5'h01;
          next_dacCode[bitPtr - 5'h01] = 1'b1;
        end else begin
          next_result = next_dacCode;
          next_resultReady = 1'b1;
          next_state = ST_ACQUIRE;
          next_trackHold = 1'b1;
          next_count = 6'h00;
        end
      end
      ST_ACQUIRE: begin
        if (count == ACQ_LAST) begin
          next_state = ST_IDLE;
        end else begin
          next_count = count + 6'h01;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_trackHold = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      count <= 6'h00;
      bitPtr <= 5'h00;
      dacCode <= RESULT_RESET;
      result <= RESULT_RESET;
      trackHold <= 1'b1;
      resultReady <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      bitPtr <= next_bitPtr;
      dacCode <= next_dacCode;
      result <= next_result;
      trackHold <= next_trackHold;
      resultReady <= next_resultReady;
    end
  end

  // ***************************************
  // Serial port and reference mode
  // ***************************************
  logic selected;
  logic next_selected;
  logic [RESULT_BITS-1:0] outShift;
  logic [RESULT_BITS-1:0] next_outShift;
  logic [4:0] outCount;
  logic [4:0] next_outCount;
  logic next_serialOut;
  logic next_serialOutEn;
  logic [CFG_BITS-1:0] cfgShift;
  logic [CFG_BITS-1:0] next_cfgShift;
  logic [3:0] cfgCount;
  logic [3:0] next_cfgCount;
  logic [1:0] next_refMode;
  logic next_bandgapOutputSwitch;
  logic next_bufferPathSwitch;

  always_comb begin
    next_selected = selected;
    next_outShift = outShift;
    next_outCount = outCount;
    next_serialOut = serialOut;
    next_serialOutEn = serialOutEn;
    next_cfgShift = cfgShift;
    next_cfgCount = cfgCount;
    next_refMode = refMode;
    if (cnvRise) begin
      next_selected = 1'b0;
      next_serialOutEn = 1'b0;
      next_cfgCount = 4'h0;
    end else if (cnvFall && shiftLevel && !selected) begin
      next_selected = 1'b1;
      next_outShift = result;
      next_outCount = 5'h00;
      next_serialOut = result[MSB_INDEX];
      next_serialOutEn = 1'b1;
      next_cfgCount = 4'h0;
    end else if (selected && shiftFall) begin
      next_outShift = {outShift[RESULT_BITS-2:0], 1'b0};
      next_serialOut = outShift[RESULT_BITS-2];
      if (outCount == MSB_INDEX) begin
        next_serialOutEn = 1'b0;
      end else begin
        next_outCount = outCount + 5'h01;
      end
    end else if (selected && shiftRise) begin
      next_cfgShift = {cfgShift[CFG_BITS-2:0], serialIn};
      if (cfgCount == CFG_LAST) begin
        next_refMode = next_cfgShift[MODE_MSB:MODE_LSB];
        next_cfgCount = 4'h0;
      end else begin
        next_cfgCount = cfgCount + 4'h1;
      end
    end
    // Bandgap switch closed in 00 and 10, buffer live in 00 and 01
    next_bandgapOutputSwitch = ~next_refMode[0];
    next_bufferPathSwitch = ~next_refMode[1];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      selected <= 1'b0;
      outShift <= RESULT_RESET;
      outCount <= 5'h00;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
      cfgShift <= CFG_RESET;
      cfgCount <= 4'h0;
      refMode <= REF_MODE_RESET;
      bandgapOutputSwitch <= 1'b1;
      bufferPathSwitch <= 1'b1;
    end else begin
      selected <= next_selected;
      outShift <= next_outShift;
      outCount <= next_outCount;
      serialOut <= next_serialOut;
      serialOutEn <= next_serialOutEn;
      cfgShift <= next_cfgShift;
      cfgCount <= next_cfgCount;
      refMode <= next_refMode;
      bandgapOutputSwitch <= next_bandgapOutputSwitch;
      bufferPathSwitch <= next_bufferPathSwitch;
    end
  end

  // ***************************************
  // Assertions
  // ***************************************
  // Pin rise to result within the limit, less sync and edge compare
  localparam int ConvBound = CONV_MAX_CYCLES - 3;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_start;
    cnvRise && state == ST_IDLE |=> state == ST_CONVERT && !trackHold;
  endproperty
  a_start: assert property (p_start) else $error("Rise did not start conversion");

  property p_select;
    $rose(selected) |-> $past(cnvFall) && $past(shiftLevel);
  endproperty
  a_select: assert property (p_select) else $error("Selected without valid edge");

  property p_out_edge;
    $changed(serialOut) && $past(selected) |-> $past(shiftFall);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("Output changed off falling edge");

  property p_in_edge;
    $changed(cfgShift) |-> $past(shiftRise) && $past(selected);
  endproperty
  a_in_edge: assert property (p_in_edge) else $error("Input taken off rising edge");

  property p_deselected;
    !selected && !cnvFall |=> $stable(outShift);
  endproperty
  a_deselected: assert property (p_deselected) else $error("Output advanced deselected");

  property p_word_mode;
    selected && shiftRise && !cnvRise && cfgCount == CFG_LAST
      |=> refMode == $past(cfgShift[MODE_MSB-1:MODE_LSB-1]);
  endproperty
  a_word_mode: assert property (p_word_mode) else $error("Mode not taken from bits 5:4");

  property p_partial;
    $changed(refMode) |-> $past(cfgCount) == CFG_LAST && $past(shiftRise);
  endproperty
  a_partial: assert property (p_partial) else $error("Mode changed mid word");

  property p_mode00;
    refMode == REF_INT_BUF |-> bandgapOutputSwitch && bufferPathSwitch;
  endproperty
  a_mode00: assert property (p_mode00) else $error("Mode 00 switches wrong");

  property p_mode01;
    refMode == REF_EXT_BUF |-> !bandgapOutputSwitch && bufferPathSwitch;
  endproperty
  a_mode01: assert property (p_mode01) else $error("Mode 01 switches wrong");

  property p_mode10;
    refMode == REF_INT_NOBUF |-> bandgapOutputSwitch && !bufferPathSwitch;
  endproperty
  a_mode10: assert property (p_mode10) else $error("Mode 10 switches wrong");

  property p_mode11;
    refMode == REF_OFF |-> !bandgapOutputSwitch && !bufferPathSwitch;
  endproperty
  a_mode11: assert property (p_mode11) else $error("Mode 11 switches wrong");

  property p_resolve;
    $fell(trackHold) |-> !trackHold [*8] ##11 $rose(trackHold) && resultReady;
  endproperty
  a_resolve: assert property (p_resolve) else $error("Resolution not 18 cycles");

  property p_acquire;
    $rose(trackHold) |-> (state == ST_ACQUIRE) [*8] ##5 state == ST_ACQUIRE ##1 state == ST_IDLE;
  endproperty
  a_acquire: assert property (p_acquire) else $error("Acquire not 13 cycles");

  property p_same_sample;
    (resultReady |-> result == dacCode) and (!resultReady |-> $stable(result));
  endproperty
  a_same_sample: assert property (p_same_sample) else $error("Result not from this sample");

  property p_latency;
    cnvRise && state == ST_IDLE |-> ##[1:ConvBound] resultReady;
  endproperty
  a_latency: assert property (p_latency) else $error("Result late");

  c_select: cover property ($rose(selected));
  c_word: cover property ($changed(refMode));
  c_done: cover property (resultReady);
  c_read_all: cover property ($fell(serialOutEn) && selected);
endmodule

// file: adc_ctrl_pkg.sv
// Constants and types shared by the converter control design
package adc_ctrl_pkg;
  // ***************************************
  // Widths and field layout
  // ***************************************
  localparam int RESULT_BITS = 18;
  localparam int CFG_BITS = 8;
  localparam int MODE_MSB = 5;
  localparam int MODE_LSB = 4;
  localparam int SYNC_BITS = 3;
  localparam int SYNC_CNV = 2;
  localparam int SYNC_SCLK = 1;
  localparam int SYNC_DIN = 0;

  // ***************************************
  // Timing
  // ***************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int ACQ_TIME_NS = 500;
  localparam int CONV_TIME_NS = 1500;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [5:0] ACQ_LAST = 6'(ACQ_CYCLES - 1);
  localparam logic [4:0] MSB_INDEX = 5'(RESULT_BITS - 1);
  localparam logic [3:0] CFG_LAST = 4'(CFG_BITS - 1);

  // ***************************************
  // Reference modes and states
  // ***************************************
  typedef enum logic [1:0] {
    REF_INT_BUF = 2'b00,
    REF_EXT_BUF = 2'b01,
    REF_INT_NOBUF = 2'b10,
    REF_OFF = 2'b11
  } ref_mode_t;

  localparam ref_mode_t REF_MODE_RESET = REF_INT_BUF;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 18'h00000;
  localparam logic [CFG_BITS-1:0] CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_ACQUIRE = 2'b10
  } conv_state_t;
endpackage

// file: signal_sync.sv
// Two-stage synchroniser for pin inputs
module signal_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule

// file: edge_detect.sv
// Rise and fall pulses of a synchronised level
module edge_detect (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = level;
    rise = level & ~prev;
    fall = ~level & prev;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule

// file: host_serial_model.sv
// Host serial controller model driving convert start, shift clock and data in
module host_serial_model
  import adc_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic serialOut,
  output logic convertStartPin,
  output logic shiftClkPin,
  output logic serialInPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half of the 320 ns shift clock period, in 40 ns cycles
  localparam int HALF_CYC = 4;
  logic [RESULT_BITS-1:0] readWord;

  initial begin
    convertStartPin = 1'b0;
    shiftClkPin = 1'b0;
    serialInPin = 1'b0;
    readWord = '0;
  end

  // ***************************************
  // Host operations
  // ***************************************
  task ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Bench restarts far faster than ten per second
  task start_conv();
    convertStartPin <= 1'b1;
  endtask

  // Pin falls with clock at selHigh; nRise limits rising edges sent
  task read_frame(input logic [CFG_BITS-1:0] cfg, input int nRise, input logic selHigh);
    int i;
    shiftClkPin <= selHigh;
    ticks(HALF_CYC);
    convertStartPin <= 1'b0;
    ticks(2 * HALF_CYC);
    for (i = 0; i < RESULT_BITS; i++) begin
      readWord[RESULT_BITS-1-i] = serialOut;
      shiftClkPin <= 1'b0;
      // Data set up at the fall, ahead of the rise; spare rises repeat the word
      serialInPin <= cfg[CFG_BITS-1-(i % CFG_BITS)];
      ticks(HALF_CYC);
      if (i < nRise) begin
        shiftClkPin <= 1'b1;
      end
      ticks(HALF_CYC);
    end
    serialInPin <= ~serialInPin;
  endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the converter control block
module tb_top
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [RESULT_BITS-1:0] vin;
    logic [CFG_BITS-1:0] cfg;
  } row_t;
  logic sys_clk;
  logic rst_b;
  logic convertStartPin, shiftClkPin, serialInPin, compKeep;
  logic [RESULT_BITS-1:0] vin, dacCode;
  logic trackHold, resultReady, serialOut, serialOutEn;
  logic bandgapOutputSwitch, bufferPathSwitch;
  logic [1:0] refMode;
  int n_fail = 0;
  int num_checks = 0;
  row_t rows [4] = '{'{18'h15555, 8'hCF}, '{18'h3FFFF, 8'h10}, '{18'h00000, 8'hEF},
    '{18'h2AAAA, 8'h30}};

  // Comparator of an ideal input held at vin
  assign compKeep = (vin >= dacCode);

  host_serial_model i_host (.sys_clk(sys_clk), .serialOut(serialOut),
    .convertStartPin(convertStartPin), .shiftClkPin(shiftClkPin), .serialInPin(serialInPin));

  adc_conversion_reference_control i_dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .convertStartPin(convertStartPin), .shiftClkPin(shiftClkPin), .serialInPin(serialInPin),
    .compKeep(compKeep), .dacCode(dacCode), .trackHold(trackHold), .resultReady(resultReady),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .refMode(refMode),
    .bandgapOutputSwitch(bandgapOutputSwitch), .bufferPathSwitch(bufferPathSwitch));

  initial begin
    sys_clk = 1'b0;
  end
  always #20 sys_clk = ~sys_clk;

  // ***************************************
  // Shared tasks
  // ***************************************
  task automatic check(input logic [RESULT_BITS-1:0] seen, exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic conv(input logic [RESULT_BITS-1:0] v);
    int n;
    int low;
    n = 0;
    low = 0;
    vin <= v;
    i_host.start_conv();
    while (resultReady !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (trackHold === 1'b0) low++;
      if (n >= 60) begin
        check(18'(resultReady), 18'h00001, "no result");
        end_of_test();
      end
    end
    @(posedge sys_clk);
    check(18'(low), 18'(RESULT_BITS), "hold cycles");
    check(18'(n <= CONV_MAX_CYCLES), 18'h00001, "result late");
  endtask

  task automatic check_mode(input logic [1:0] m);
    check(18'(refMode), 18'(m), "mode");
    check(18'({bandgapOutputSwitch, bufferPathSwitch}),
      18'({m == 2'b00 || m == 2'b10, m == 2'b00 || m == 2'b01}), "switches");
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    check(18'h00000, 18'h00001, "run timeout");
    end_of_test();
  end

  // ***************************************
  // Main sequence
  // ***************************************
  initial begin
    rst_b = 1'b0;
    vin = '0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    check(18'({trackHold, resultReady, serialOutEn}), 18'h00004, "reset outputs");
    check_mode(2'b00);
    $display("reset done");
    @(posedge sys_clk);
    foreach (rows[k]) begin
      conv(rows[k].vin);
      i_host.read_frame(rows[k].cfg, 18, 1'b1);
      check(i_host.readWord, rows[k].vin, "result");
      check(18'(serialOutEn), 18'h00000, "enable after frame");
      check_mode(rows[k].cfg[MODE_MSB:MODE_LSB]);
      $display("row %0d done", k);
    end
    conv(18'h12345);
    i_host.read_frame(8'h00, 4, 1'b1);
    check_mode(2'b11);
    $display("partial word done");
    conv(18'h0ABCD);
    i_host.read_frame(8'h00, 18, 1'b0);
    check_mode(2'b11);
    check(18'(serialOutEn), 18'h00000, "deselected drive");
    $display("deselected frame done");
    conv(18'h1D2C3);
    i_host.read_frame(8'h20, 18, 1'b1);
    check(i_host.readWord, 18'h1D2C3, "fresh result");
    check_mode(2'b10);
    $display("reselect done");
    end_of_test();
  end
endmodule
